// *** src/cmoc_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmoc_core #(
	parameter logic [cmoc_pkg::TW-1:0] P_WIN_CYC   =
		cmoc_pkg::TW'(cmoc_pkg::WIN_CYC),
	parameter logic [cmoc_pkg::TW-1:0] P_QCAL_CYC  =
		cmoc_pkg::TW'(cmoc_pkg::QCAL_CYC),
	parameter logic [cmoc_pkg::TW-1:0] P_HOLD_CYC  =
		cmoc_pkg::TW'(cmoc_pkg::HOLD_CYC),
	parameter logic [cmoc_pkg::TW-1:0] P_RECAL_CYC =
		cmoc_pkg::TW'(cmoc_pkg::RECAL_CYC),
	parameter logic [cmoc_pkg::TW-1:0] P_SD_CYC    =
		cmoc_pkg::TW'(cmoc_pkg::SD_CYC)
) (
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	input  wire logic                checksum_ok,
	input  wire logic                conv_valid,
	input  wire logic signed [15:0]  conv_data,
	input  wire logic                volt_valid,
	input  wire logic [15:0]         volt_data,
	input  wire logic                temp_valid,
	input  wire logic signed [15:0]  temp_data,
	input  wire cmoc_pkg::cmoc_cfg_t cfg,
	input  wire logic                link_level,
	input  wire logic                reg_wr,
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	output var  logic [7:0]          reg_rdata,
	output var  logic                calibration_in_progress_flag,
	output var  logic                cal_short,
	output var  logic                cap_inaccurate,
	output var  logic                edv1_flag,
	output var  logic                edvf_flag,
	output var  logic                sleep,
	output var  cmoc_pkg::cmoc_res_t res,
	output var  cmoc_pkg::cmoc_tte_t tte
);

	// ****************************************
	// Calibration scheduler
	// ****************************************
	cmoc_pkg::cmoc_state_t  state;
	logic [cmoc_pkg::TW-1:0] ph_cnt;
	logic [cmoc_pkg::TW-1:0] ph_len;
	logic                    ph_end;
	logic signed [31:0]      cal_sum;
	logic signed [15:0]      offset;
	logic                    first_hold;
	logic [7:0]              host_control;
	logic signed [16:0]      corr;
	logic [16:0]             mag;
	logic                    keep;

	function automatic logic signed [15:0] avg(
		input logic signed [31:0] s,
		input logic [31:0]        r
	);
		logic signed [63:0] p;
		p = 64'(s) * $signed(64'(r));
		return p[47:32];
	endfunction : avg

	// Phase length depends on what the scheduler is waiting for
	always_comb begin
		unique case (state)
			cmoc_pkg::ST_SETTLE,
			cmoc_pkg::ST_QUICK: ph_len = P_QCAL_CYC;
			cmoc_pkg::ST_IDLE:  ph_len = first_hold ? P_HOLD_CYC : P_RECAL_CYC;
			default:            ph_len = P_WIN_CYC;
		endcase
		ph_end = (ph_cnt == ph_len - 1'b1);
	end

	// Offset sampling sequence; samples are raw, the input is shorted
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state      <= cmoc_pkg::ST_BOOT;
			ph_cnt     <= '0;
			cal_sum    <= '0;
			offset     <= '0;
			first_hold <= 1'b0;
		end else begin
			ph_cnt <= ph_end ? '0 : ph_cnt + 1'b1;
			if (conv_valid)
				cal_sum <= cal_sum + 32'(conv_data);
			unique case (state)
				cmoc_pkg::ST_BOOT: begin
					ph_cnt     <= '0;
					cal_sum    <= '0;
					first_hold <= !checksum_ok;                 // R8
					state      <= checksum_ok ? cmoc_pkg::ST_FULL
						: cmoc_pkg::ST_SETTLE;                // R19
				end
				cmoc_pkg::ST_SETTLE: if (ph_end) begin
					cal_sum <= '0;
					if (host_control[cmoc_pkg::CTRL_FAST_BIT]) begin
						offset <= avg(cal_sum, cmoc_pkg::QCAL_RECIP); // R10
						state  <= cmoc_pkg::ST_IDLE;
					end else
						state <= cmoc_pkg::ST_QUICK;             // R9
				end
				cmoc_pkg::ST_QUICK: if (ph_end) begin
					offset <= avg(cal_sum, cmoc_pkg::QCAL_RECIP);   // R9
					state  <= cmoc_pkg::ST_IDLE;
				end
				cmoc_pkg::ST_IDLE: begin
					cal_sum <= '0;
					if (ph_end)
						state <= cmoc_pkg::ST_FULL;               // R5
				end
				cmoc_pkg::ST_FULL: if (ph_end) begin
					offset     <= avg(cal_sum, cmoc_pkg::WIN_RECIP);
					first_hold <= 1'b0;
					state      <= cmoc_pkg::ST_IDLE;
				end
				default: state <= cmoc_pkg::ST_BOOT;
			endcase
		end
	end

	// Flag follows the state, so it drops only after the new offset lands
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			calibration_in_progress_flag <= 1'b0;
			cal_short                    <= 1'b0;
		end else begin
			calibration_in_progress_flag <= state == cmoc_pkg::ST_SETTLE
				|| state == cmoc_pkg::ST_QUICK
				|| state == cmoc_pkg::ST_FULL;                 // R6 R20
			cal_short <= state == cmoc_pkg::ST_SETTLE
				|| state == cmoc_pkg::ST_QUICK || state == cmoc_pkg::ST_FULL;
		end
	end

	// ****************************************
	// Host control register and user offset
	// ****************************************
	logic               uofs_busy;
	logic [cmoc_pkg::TW-1:0] uofs_cnt;
	logic signed [31:0] uofs_sum;
	logic               uofs_done;

	assign uofs_done = uofs_busy && uofs_cnt == P_WIN_CYC - 1'b1;

	// Host write of the command bit wins over the hardware clear
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			host_control <= cmoc_pkg::CTRL_RST;
			reg_rdata    <= '0;
		end else begin
			if (reg_wr && reg_addr == cmoc_pkg::CTRL_ADDR)
				host_control <= reg_wdata;                        // R10
			else if (uofs_done)
				host_control[cmoc_pkg::CTRL_UOFS_BIT] <= 1'b0;
			reg_rdata <= (reg_addr == cmoc_pkg::CTRL_ADDR) ? host_control
				: '0;
		end
	end

	// One window of internally corrected samples gives the board offset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			uofs_busy       <= 1'b0;
			uofs_cnt        <= '0;
			uofs_sum        <= '0;
			res.user_offset <= '0;
		end else if (!uofs_busy) begin
			uofs_busy <= host_control[cmoc_pkg::CTRL_UOFS_BIT];
			uofs_cnt  <= '0;
			uofs_sum  <= '0;
		end else begin
			uofs_cnt <= uofs_cnt + 1'b1;
			if (conv_valid)
				uofs_sum <= uofs_sum + 32'(conv_data - offset);   // R11
			if (uofs_done) begin
				uofs_busy       <= 1'b0;
				res.user_offset <= avg(uofs_sum, cmoc_pkg::WIN_RECIP);
			end
		end
	end

	// ****************************************
	// Charge integration and magnitude filter
	// ****************************************
	// Internal and board offsets are both removed before filtering
	always_comb begin
		corr = 17'(conv_data) - 17'(offset) - 17'(cfg.ext_offset); // R11
		mag  = corr[16] ? 17'(-corr) : corr;
		keep = (cfg.filt_thresh == '0) ? (corr != '0)              // R14
			: (mag >= 17'(cfg.filt_thresh));                      // R12 R13
	end

	logic signed [31:0]      fine;
	logic [cmoc_pkg::TW-1:0] sd_cnt;
	logic                    sd_tick;
	logic [15:0]             cap;
	logic [15:0]             edv1_cap;

	assign sd_tick  = sd_cnt == P_SD_CYC - 1'b1;
	assign cap      = res.capacity;
	assign edv1_cap = cfg.design_cap >> cmoc_pkg::EDV1_SHIFT;

	// Fine accumulator carries the fraction of one capacity step
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fine           <= '0;
			sd_cnt         <= '0;
			res.capacity   <= '0;
			cap_inaccurate <= 1'b0;
		end else if (state == cmoc_pkg::ST_BOOT) begin
			res.capacity   <= checksum_ok ? cfg.retained_cap : '0; // R19
			cap_inaccurate <= !checksum_ok;                         // R19
		end else begin
			sd_cnt <= sd_tick ? '0 : sd_cnt + 1'b1;
			if (conv_valid && keep)
				fine <= fine + 32'(corr);                          // R1
			else if (fine >= cmoc_pkg::CAP_STEP) begin
				fine         <= fine - cmoc_pkg::CAP_STEP;       // R2
				res.capacity <= cap + 1'b1;
			end else if (fine <= -cmoc_pkg::CAP_STEP) begin
				fine         <= fine + cmoc_pkg::CAP_STEP;
				res.capacity <= (cap == '0) ? cap : cap - 1'b1;
			end else if (sd_tick) begin
				// Warm cells lose charge faster
				res.capacity <= (cap < cmoc_pkg::SD_WARM) ? '0
					: cap - ((res.temperature >= cfg.temp_comp)
					? cmoc_pkg::SD_WARM : cmoc_pkg::SD_COLD);    // R17
			end
			if (edvf_flag)
				res.capacity <= '0;                                 // R16
			else if (edv1_flag && cap > edv1_cap)
				res.capacity <= edv1_cap;                           // R16
		end
	end

	// ****************************************
	// Current window, voltage and temperature
	// ****************************************
	logic [cmoc_pkg::TW-1:0] win_cnt;
	logic signed [31:0]      cur_sum;
	logic                    win_end;
	logic                    frozen;

	assign win_end = win_cnt == P_WIN_CYC - 1'b1;
	assign frozen  = state == cmoc_pkg::ST_FULL;

	// Current is only refreshed once per window, never mid-window
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			win_cnt     <= '0;
			cur_sum     <= '0;
			res.current <= '0;
		end else begin
			win_cnt <= win_end ? '0 : win_cnt + 1'b1;
			if (win_end) begin
				cur_sum <= '0;
				if (!frozen)                                          // R7
					res.current <= avg(cur_sum, cmoc_pkg::WIN_RECIP);   // R4
			end else if (conv_valid)
				cur_sum <= cur_sum + 32'(corr);
		end
	end

	// Voltage, temperature and compensated capacity run through calibration
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			res.voltage       <= '0;
			res.temperature   <= '0;
			res.comp_capacity <= '0;
			edv1_flag         <= 1'b0;
			edvf_flag         <= 1'b0;
		end else begin
			if (volt_valid) begin
				res.voltage <= volt_data - cfg.volt_offset;             // R15
				edv1_flag   <= volt_data - cfg.volt_offset
					<= cfg.edv1_thresh;                               // R15
				edvf_flag   <= volt_data - cfg.volt_offset
					<= cfg.edvf_thresh;
			end
			if (temp_valid)
				res.temperature <= temp_data;
			// Cold cells deliver less; derate by a fixed fraction
			res.comp_capacity <= (res.temperature < cfg.temp_comp)
				? cap - (cap >> cmoc_pkg::COLD_SHIFT) : cap;         // R17
		end
	end

	// Link held low means the host is gone
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			sleep <= 1'b0;
		else
			sleep <= !link_level;                                   // R18
	end

	// ****************************************
	// Time-to-empty divider
	// ****************************************
	// One shared serial divider, three loads in turn, 33 cycles each
	logic        dv_busy;
	logic [1:0]  dv_sel;
	logic [5:0]  dv_bit;
	logic [31:0] dv_num;
	logic [31:0] dv_quo;
	logic [32:0] dv_rem;
	logic [32:0] dv_try;
	logic [31:0] dv_den;
	logic [15:0] load;
	logic [15:0] dv_res;

	always_comb begin
		unique case (dv_sel)
			2'h0:    load = cfg.standby_load;
			2'h1:    load = res.current[15] ? 16'(-res.current) : '0;
			default: load = cfg.at_rate;
		endcase
		dv_den = 32'(load) * 32'(cmoc_pkg::TTE_DEN_K);
		dv_try = {dv_rem[31:0], dv_num[31]};
		// Zero load yields all ones, which saturates to the top value
		dv_res = (dv_quo[31:16] != '0) ? 16'hffff : dv_quo[15:0];
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dv_busy <= 1'b0;
			dv_sel  <= '0;
			dv_bit  <= '0;
			dv_num  <= '0;
			dv_quo  <= '0;
			dv_rem  <= '0;
			tte     <= '0;
		end else if (!dv_busy) begin
			dv_sel <= '0;
			dv_bit <= '0;
			dv_rem <= '0;
			dv_num <= 32'(res.comp_capacity) * 32'(cmoc_pkg::TTE_K);
			dv_busy <= win_end && !frozen;                            // R7
		end else if (frozen) begin
			// A calibration began mid-divide: drop it so tte stays put
			dv_busy <= 1'b0;                                          // R7
		end else begin
			dv_bit <= dv_bit + 1'b1;
			dv_num <= {dv_num[30:0], 1'b0};
			if (dv_try >= 33'(dv_den)) begin
				dv_rem <= dv_try - 33'(dv_den);
				dv_quo <= {dv_quo[30:0], 1'b1};
			end else begin
				dv_rem <= dv_try;
				dv_quo <= {dv_quo[30:0], 1'b0};
			end
			if (dv_bit == 6'h20) begin
				unique case (dv_sel)
					2'h0:    tte.standby  <= dv_res;                    // R3
					2'h1:    tte.measured <= dv_res;                    // R3
					default: tte.at_rate  <= dv_res;                    // R3
				endcase
				dv_bit  <= '0;
				dv_rem  <= '0;
				dv_num  <= 32'(res.comp_capacity) * 32'(cmoc_pkg::TTE_K);
				dv_sel  <= dv_sel + 1'b1;
				dv_busy <= dv_sel != 2'h2;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_settle_end;
		state == cmoc_pkg::ST_SETTLE && ph_end;
	endsequence

	sequence s_full_end;
		state == cmoc_pkg::ST_FULL && ph_end;
	endsequence

	property p_cal_flag;
		state == cmoc_pkg::ST_QUICK |=> calibration_in_progress_flag;
	endproperty
	a_cal_flag: assert property (p_cal_flag) // R6
		else $error("Flag low during calibration");

	property p_cal_clear;
		s_full_end |=> calibration_in_progress_flag ##1
			!calibration_in_progress_flag;
	endproperty
	a_cal_clear: assert property (p_cal_clear) // R20
		else $error("Flag not cleared after calibration");

	property p_fast;
		s_settle_end ##0 host_control[cmoc_pkg::CTRL_FAST_BIT]
			|=> state == cmoc_pkg::ST_IDLE
			&& offset == avg($past(cal_sum), cmoc_pkg::QCAL_RECIP);
	endproperty
	a_fast: assert property (p_fast) // R10
		else $error("Early bit did not skip second sample");

	property p_slow;
		s_settle_end ##0 !host_control[cmoc_pkg::CTRL_FAST_BIT]
			|=> state == cmoc_pkg::ST_QUICK && $stable(offset);
	endproperty
	a_slow: assert property (p_slow) // R9
		else $error("Settle sample was not discarded");

	property p_full_reset;
		state == cmoc_pkg::ST_BOOT && !checksum_ok
			|=> state == cmoc_pkg::ST_SETTLE && cap_inaccurate
			&& res.capacity == '0;
	endproperty
	a_full_reset: assert property (p_full_reset) // R19
		else $error("Full reset not applied");

	property p_filter;
		conv_valid && keep == 1'b0 && fine < cmoc_pkg::CAP_STEP
			&& fine > -cmoc_pkg::CAP_STEP |=> $stable(fine);
	endproperty
	a_filter: assert property (p_filter) // R12
		else $error("Filtered sample reached accumulator");

	property p_freeze;
		frozen |=> $stable(res.current) && $stable(tte);
	endproperty
	a_freeze: assert property (p_freeze) // R7
		else $error("Derived value changed during calibration");

	property p_empty;
		edvf_flag && state != cmoc_pkg::ST_BOOT |=> res.capacity == '0;
	endproperty
	a_empty: assert property (p_empty) // R16
		else $error("Capacity not forced empty");

	property p_sleep;
		!link_level[*2] |=> sleep;
	endproperty
	a_sleep: assert property (p_sleep) // R18
		else $error("Sleep not entered on low link");

endmodule : cmoc_core
`default_nettype wire

// *** src/cmoc_pkg.sv ***
// Overview of operation
// R1 - Integrate sense voltage continuously into charge
// R2 - Capacity step equals 3.57 uVh
// R3 - Time-to-empty in minutes for three loads
// R4 - Current is 5.12 s window average
// R5 - Recalibrate offset periodically without host action
// R6 - Flag set while calibration runs
// R7 - Full calibration freezes derived values except basics
// R8 - After full reset quick cal, hold 40 s
// R9 - Quick cal: settle sample, then offset sample
// R10 - Control bit 0 early adopts first sample
// R11 - User offset command; external offset added
// R12 - Drop accumulations below magnitude threshold
// R13 - Threshold counts steps of 4.9 uV
// R14 - Zero threshold disables the filter
// R15 - Offset-corrected voltage compared to thresholds
// R16 - Threshold forces capacity to 6.25% or empty
// R17 - Temperature adjusts compensation and self-discharge
// R18 - Sleep when communication lines are low
// R19 - Checksum failure: clear data, flag inaccurate
// R20 - Clear flag after offset applied
package cmoc_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam longint unsigned CLK_KHZ  = 200000; // 200 MHz
	localparam longint unsigned WIN_MS   = 5120;   // 5.12 s window
	localparam longint unsigned QCAL_MS  = 1280;   // 1.28 s quick sample
	localparam longint unsigned HOLD_MS  = 40000;  // 40 s hold-off
	localparam longint unsigned RECAL_MS = 60000;  // Recalibration period
	localparam longint unsigned SD_MS    = 1000;   // Self-discharge tick
	localparam longint unsigned SMP_US   = 1000;   // Converter sample period
	localparam int              TW       = 34;
	localparam longint unsigned WIN_CYC   = WIN_MS * CLK_KHZ;
	localparam longint unsigned QCAL_CYC  = QCAL_MS * CLK_KHZ;
	localparam longint unsigned HOLD_CYC  = HOLD_MS * CLK_KHZ;
	localparam longint unsigned RECAL_CYC = RECAL_MS * CLK_KHZ;
	localparam longint unsigned SD_CYC    = SD_MS * CLK_KHZ;
	localparam longint unsigned WIN_SMP   = WIN_MS * 1000 / SMP_US;
	localparam longint unsigned QCAL_SMP  = QCAL_MS * 1000 / SMP_US;
	localparam logic [31:0] WIN_RECIP  = 32'((64'h1 << 32) / WIN_SMP);
	localparam logic [31:0] QCAL_RECIP = 32'((64'h1 << 32) / QCAL_SMP);

	// ****************************************
	// Scaling
	// ****************************************
	localparam longint unsigned CAP_UVH_X100 = 357;  // 3.57 uVh
	localparam longint unsigned LSB_NV       = 4900; // 4.9 uV per count
	// 1000 nV per uV times 3.6e9 us per hour; sized to stay out of 32 bits
	localparam longint unsigned NVUS_PER_UVH = 64'd3600000000 * 64'd1000;
	localparam logic signed [31:0] CAP_STEP =
		32'(CAP_UVH_X100 * NVUS_PER_UVH / 100 / (LSB_NV * SMP_US));
	localparam logic [15:0] TTE_K     = 16'(CAP_UVH_X100 * 60000 / LSB_NV);
	localparam logic [7:0]  TTE_DEN_K = 8'h64; // Scale of TTE_K
	localparam int          EDV1_SHIFT = 4;    // 6.25 % = 1/16
	localparam int          COLD_SHIFT = 3;
	localparam logic [15:0] SD_WARM   = 16'h0002;
	localparam logic [15:0] SD_COLD   = 16'h0001;

	// ****************************************
	// Host control register
	// ****************************************
	localparam logic [7:0] CTRL_ADDR     = 8'h00;
	localparam logic [7:0] CTRL_RST      = 8'h00;
	localparam int         CTRL_FAST_BIT = 0;
	localparam int         CTRL_UOFS_BIT = 1;

	typedef enum logic [2:0] {
		ST_BOOT   = 3'b000,
		ST_SETTLE = 3'b001,
		ST_QUICK  = 3'b010,
		ST_IDLE   = 3'b011,
		ST_FULL   = 3'b100
	} cmoc_state_t;

	typedef struct packed {
		logic [15:0]        retained_cap;
		logic signed [15:0] ext_offset;
		logic [15:0]        filt_thresh;
		logic [15:0]        volt_offset;
		logic [15:0]        edv1_thresh;
		logic [15:0]        edvf_thresh;
		logic signed [15:0] temp_comp;
		logic [15:0]        design_cap;
		logic [15:0]        standby_load;
		logic [15:0]        at_rate;
	} cmoc_cfg_t;

	typedef struct packed {
		logic [15:0]        capacity;
		logic [15:0]        comp_capacity;
		logic signed [15:0] current;
		logic [15:0]        voltage;
		logic signed [15:0] temperature;
		logic signed [15:0] user_offset;
	} cmoc_res_t;

	typedef struct packed {
		logic [15:0] standby;
		logic [15:0] measured;
		logic [15:0] at_rate;
	} cmoc_tte_t;

endpackage : cmoc_pkg

// *** verification/cmoc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host side of the register link
// ****************************************
module cmoc_host_model (
	input  wire logic       sys_clk,
	input  wire logic [7:0] reg_rdata,
	output var  logic       reg_wr,
	output var  logic [7:0] reg_addr,
	output var  logic [7:0] reg_wdata,
	output var  logic       link_level
);
	// Powered host holds the line high, no strobe pending
	initial begin
		reg_wr     = 1'b0;
		reg_addr   = 8'h00;
		reg_wdata  = 8'h00;
		link_level = 1'b1;
	end

	// One strobe held over a single rising edge
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_wr    = 1'b1;
		reg_addr  = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr    = 1'b0;
		reg_wdata = ~d; // Released data must not look valid
	endtask : write

	// Read data is registered, so it is taken one edge later
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask : read

	// Dropping host power lets the pull-down win
	task automatic set_link(input logic v);
		@(negedge sys_clk);
		link_level = v;
	endtask : set_link
endmodule : cmoc_host_model
`default_nettype wire

// *** verification/coulomb_measure_offset_cal_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module coulomb_measure_offset_cal_tb_top;
	logic                sys_clk;
	logic                rst_n;
	logic                checksum_ok;
	logic                conv_valid;
	logic signed [15:0]  conv_data;
	logic                volt_valid;
	logic [15:0]         volt_data;
	logic                temp_valid;
	logic signed [15:0]  temp_data;
	cmoc_pkg::cmoc_cfg_t cfg;
	logic                link_level;
	logic                reg_wr;
	logic [7:0]          reg_addr;
	logic [7:0]          reg_wdata;
	logic [7:0]          reg_rdata;
	logic                cal_flag;
	logic                cap_inaccurate;
	logic                edv1_flag;
	logic                edvf_flag;
	logic                sleep;
	cmoc_pkg::cmoc_res_t res;
	logic                cal_short;
	cmoc_pkg::cmoc_tte_t tte;
	logic [7:0]          rd;
	int                  fails;
	int                  total_checks;
	int                  cyc;
	int                  edges[$];
	logic                prev;

	// Short counts keep the run to about a thousand cycles
	cmoc_core #(.P_WIN_CYC(34'h40), .P_QCAL_CYC(34'h10),
		.P_HOLD_CYC(34'hc8), .P_RECAL_CYC(34'h12c),
		.P_SD_CYC(34'h3e8)) dut_u (
		.sys_clk(sys_clk), .rst_n(rst_n), .checksum_ok(checksum_ok),
		.conv_valid(conv_valid), .conv_data(conv_data),
		.volt_valid(volt_valid), .volt_data(volt_data),
		.temp_valid(temp_valid), .temp_data(temp_data), .cfg(cfg),
		.link_level(link_level), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.calibration_in_progress_flag(cal_flag), .cal_short(cal_short),
		.cap_inaccurate(cap_inaccurate), .edv1_flag(edv1_flag),
		.edvf_flag(edvf_flag), .sleep(sleep), .res(res), .tte(tte));

	cmoc_host_model host_u (
		.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.link_level(link_level));

	// ****************************************
	// Clock, timeout and flag edge log
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Ceiling well above the roughly 1080 cycles the tests need
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fails++;
			conclude();
		end
	end

	// Cycle stamps of every flag change, cleared at each reset
	always @(negedge sys_clk) begin
		if (cal_flag !== prev)
			edges.push_back(cyc);
		prev = cal_flag;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Spans between flag edges may slip a cycle or two
	task automatic span(input int i, input int lo, input int hi);
		int v;
		v = edges[i+1] - edges[i];
		total_checks++;
		if (v < lo || v > hi) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, v, lo);
		end
	endtask : span

	task automatic do_reset(input logic ok);
		@(negedge sys_clk);
		rst_n       = 1'b0;
		checksum_ok = ok;
		repeat (3) @(negedge sys_clk);
		rst_n = 1'b1;
		edges.delete();
	endtask : do_reset

	// One sample per cycle for n cycles
	task automatic conv(input logic signed [15:0] d, input int n);
		@(negedge sys_clk);
		conv_valid = 1'b1;
		conv_data  = d;
		repeat (n) @(negedge sys_clk);
		conv_valid = 1'b0;
		conv_data  = ~d;
		repeat (4) @(negedge sys_clk);
	endtask : conv

	task automatic volt(input logic [15:0] d);
		@(negedge sys_clk);
		volt_valid = 1'b1;
		volt_data  = d;
		@(negedge sys_clk);
		volt_valid = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask : volt

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		rst_n            = 1'b0;
		checksum_ok      = 1'b0;
		conv_valid       = 1'b0;
		conv_data        = 16'sh0000;
		volt_valid       = 1'b0;
		volt_data        = 16'h0000;
		temp_valid       = 1'b1;
		temp_data        = 16'sh0019;
		cyc              = 0;
		fails            = 0;
		total_checks     = 0;
		cfg              = '0;
		cfg.retained_cap = 16'h0200;
		cfg.design_cap   = 16'h0100;
		cfg.edv1_thresh  = 16'h0c00;
		cfg.edvf_thresh  = 16'h0a00;
		cfg.at_rate      = 16'h0001;
		// Bad checksum: full reset with two quick samples
		do_reset(1'b0);
		repeat (3) @(negedge sys_clk);
		check(cap_inaccurate, 16'h0001);
		check(res.capacity, 16'h0000);
		host_u.write(8'h05, 8'hff);
		host_u.read(8'h05, rd);
		check(rd, 8'h00);
		host_u.read(8'h00, rd);
		check(rd, 8'h00);
		check(cal_flag, 16'h0001);
		check(cal_short, 16'h0001);
		repeat (40) @(negedge sys_clk);
		// 100 samples of 30000 pass one capacity step; the full calibration
		// overlapping the last batch only trims its offset slightly
		cfg.filt_thresh = 16'h7000;
		conv(16'sh7530, 100);
		check(res.capacity, 16'h0001);
		cfg.filt_thresh = 16'h7fff;
		conv(16'sh7530, 100);
		check(res.capacity, 16'h0001);
		cfg.filt_thresh = 16'h0000;
		conv(16'sh7530, 100);
		check(res.capacity, 16'h0002);
		repeat (600) @(negedge sys_clk);
		span(0, 30, 36);
		span(1, 196, 204);
		span(2, 62, 68);
		span(3, 296, 304);
		check(16'(edges.size() > 3), 16'h0001);
		// Capacity 2 at a load of 1; zero standby load saturates
		check(tte.at_rate, 16'(16'h0002 * cmoc_pkg::TTE_K / cmoc_pkg::TTE_DEN_K));
		check(tte.standby, 16'hffff);
		// Good checksum: data kept, full calibration at once
		do_reset(1'b1);
		repeat (3) @(negedge sys_clk);
		check(cap_inaccurate, 16'h0000);
		check(res.capacity, 16'h0200);
		volt(16'h0d00);
		check(res.voltage, 16'h0d00);
		check(edv1_flag, 16'h0000);
		volt(16'h0b00);
		check(edv1_flag, 16'h0001);
		check(res.capacity, 16'h0010);
		check(cal_flag, 16'h0001);
		// Cold reading derates by one eighth, but only once it is taken
		temp_valid = 1'b0;
		temp_data  = 16'shfffb;
		repeat (2) @(negedge sys_clk);
		check(res.comp_capacity, 16'h0010);
		temp_valid = 1'b1;
		repeat (2) @(negedge sys_clk);
		check(res.comp_capacity, 16'h000e);
		temp_data  = 16'sh0019;
		volt(16'h0900);
		check(edvf_flag, 16'h0001);
		check(res.capacity, 16'h0000);
		host_u.set_link(1'b0);
		repeat (2) @(negedge sys_clk);
		check(sleep, 16'h0001);
		host_u.set_link(1'b1);
		repeat (2) @(negedge sys_clk);
		check(sleep, 16'h0000);
		// Bit 0 written early: first sample adopted; bit 1 asks for a user
		// offset measurement, which clears itself after one window
		do_reset(1'b0);
		host_u.write(8'h00, 8'h03);
		host_u.read(8'h00, rd);
		check(rd, 8'h03);
		repeat (40) @(negedge sys_clk);
		span(0, 14, 20);
		repeat (30) @(negedge sys_clk);
		host_u.read(8'h00, rd);
		check(rd, 8'h01);
		conclude();
	end
endmodule : coulomb_measure_offset_cal_tb_top
`default_nettype wire
